// File: logic/lss_top.sv
`timescale 1ns/1ps
`include "lss_params.svh"

module lss_top
    import lss_pkg::*;
#(
    parameter int SPEED_W = 8,
    parameter int PRESS_W = 16,
    parameter int CNT_W = 40,
    parameter logic [CNT_W-1:0] PULSE_CYCLES =
        CNT_W'(`LSS_PULSE_S * `LSS_CLK_HZ),
    parameter logic [CNT_W-1:0] VALVE_ON_CYCLES =
        CNT_W'(`LSS_VALVE_ON_MS * `LSS_CLK_HZ / 64'd1000),
    parameter logic [CNT_W-1:0] VALVE_OFF_CYCLES =
        CNT_W'(`LSS_VALVE_OFF_MS * `LSS_CLK_HZ / 64'd1000),
    parameter int VALVE_PULSES = `LSS_VALVE_PULSES
)(
    input wire logic clk,
    input wire logic rstn,
    input wire lss_bus_req_t bus_req,
    output logic [31:0] bus_rdata,
    input wire logic [SPEED_W-1:0] speed,
    input wire logic [PRESS_W-1:0] pressure,
    input wire lss_evt_t evt,
    output logic driving_level_return,
    output logic [1:0] general_io_port,
    output lss_load_t load_state,
    output logic irq
);

    // Refuse widths the register port cannot carry
    if (SPEED_W < 5 || SPEED_W > 16 || PRESS_W < 4 || PRESS_W > 24)
    begin : g_chk
        $error("lss_top: unsupported speed or pressure width");
    end

    // Software registers
    logic [`LSS_CTRL_W-1:0] ctrl; // Trigger, mode and port enables
    logic [PRESS_W-1:0] part_thr; // Partial load pressure
    logic [PRESS_W-1:0] full_thr; // Full load pressure
    logic [SPEED_W-1:0] ret_spd; // Driving level return speed
    logic [SPEED_W-1:0] act_spd; // Switch activation speed
    logic [SPEED_W-1:0] deact_spd; // Switch deactivation speed
    logic [`LSS_IRQ_W-1:0] irq_stat; // Sticky events
    logic [`LSS_IRQ_W-1:0] irq_mask; // Interrupt enables

    // Block state
    logic det_valid; // A detection has completed
    logic spd_above_q; // Last cycle speed above return speed
    logic ign_q; // Last cycle ignition level
    logic act_q; // Last cycle speed at activation level
    logic armed; // Switch may fire again
    logic cont_on; // Continuous mode output level
    logic sw_q; // Last cycle switch level

    // Control fields
    wire trig_spd_en = ctrl[`LSS_CTRL_TRIG_SPD];
    wire trig_ign_en = ctrl[`LSS_CTRL_TRIG_IGN];
    wire auto_lvl = ctrl[`LSS_CTRL_AUTO_LVL];
    wire invert = ctrl[`LSS_CTRL_INVERT];
    wire lss_mode_t mode =
        lss_mode_t'(ctrl[`LSS_CTRL_MODE_HI:`LSS_CTRL_MODE_LO]);

    // Address decode
    wire sel_ctrl = (bus_req.addr == `LSS_OFS_CTRL);
    wire sel_part = (bus_req.addr == `LSS_OFS_PART_THR);
    wire sel_full = (bus_req.addr == `LSS_OFS_FULL_THR);
    wire sel_ret = (bus_req.addr == `LSS_OFS_RET_SPD);
    wire sel_act = (bus_req.addr == `LSS_OFS_ACT_SPD);
    wire sel_deact = (bus_req.addr == `LSS_OFS_DEACT_SPD);
    wire sel_stat = (bus_req.addr == `LSS_OFS_STATUS);
    wire sel_istat = (bus_req.addr == `LSS_OFS_IRQ_STAT);
    wire sel_imask = (bus_req.addr == `LSS_OFS_IRQ_MASK);
    wire wr_istat = bus_req.wr && sel_istat;

    // Load classification from live pressure
    wire below_part = (pressure < part_thr); // [R01]
    wire above_full = (pressure > full_thr); // [R03]
    wire lss_load_t load_now =
        below_part ? LSS_UNLADEN :
        above_full ? LSS_LADEN :
        LSS_PARTIAL; // [R02]

    // Detection triggers
    wire standstill = (speed == '0);
    wire spd_above = (speed > ret_spd);
    wire spd_rise = spd_above && !spd_above_q;
    wire ign_rise = evt.ignition && !ign_q;
    // Either enabled trigger may start a detection
    wire trig_sel = (trig_spd_en && spd_rise) ||
                    (trig_ign_en && ign_rise); // [R04] [R05]
    // Auto leveling overrides the trigger selection
    wire detect = auto_lvl ? standstill : trig_sel; // [R06]
    wire load_change = detect && (load_now != load_state);

    // Speed switch conditions
    wire at_act = (speed >= act_spd); // [R07]
    wire below_deact = (speed < deact_spd); // [R08]
    wire fire = at_act && !act_q && armed; // [R07]
    wire pulse_start = fire && (mode == LSS_MODE_PULSE);
    wire valve_start = fire && (mode == LSS_MODE_VALVE);
    wire pulse_lvl;
    wire valve_lvl;

    // Selected switch level before inversion
    wire sw_lvl =
        (mode == LSS_MODE_CONT) ? cont_on :
        (mode == LSS_MODE_PULSE) ? pulse_lvl :
        (mode == LSS_MODE_VALVE) ? valve_lvl :
        1'b0;
    wire sw_on = sw_lvl && !sw_q;
    wire sw_off = !sw_lvl && sw_q;

    // Interrupt event vector
    wire [`LSS_IRQ_W-1:0] irq_evt = {sw_off, sw_on, load_change, detect};

    // Read data selection
    wire [31:0] rd_val =
        sel_ctrl ? 32'({ctrl}) :
        sel_part ? 32'({part_thr}) :
        sel_full ? 32'({full_thr}) :
        sel_ret ? 32'({ret_spd}) :
        sel_act ? 32'({act_spd}) :
        sel_deact ? 32'({deact_spd}) :
        sel_stat ? 32'({sw_lvl, det_valid, load_state}) :
        sel_istat ? 32'({irq_stat}) :
        sel_imask ? 32'({irq_mask}) :
        32'h0000_0000;

    // Thirty second timed pulse
    lss_pulse_seq #(
        .CNT_W(CNT_W),
        .ON_CYC(PULSE_CYCLES),
        .OFF_CYC(PULSE_CYCLES),
        .PULSES(1)
    ) u_pulse (
        .clk(clk),
        .rstn(rstn),
        .start(pulse_start), // [R09]
        .level(pulse_lvl),
        .busy()
    );

    // Valve command sequence
    lss_pulse_seq #(
        .CNT_W(CNT_W),
        .ON_CYC(VALVE_ON_CYCLES),
        .OFF_CYC(VALVE_OFF_CYCLES),
        .PULSES(VALVE_PULSES)
    ) u_valve (
        .clk(clk),
        .rstn(rstn),
        .start(valve_start), // [R10]
        .level(valve_lvl),
        .busy()
    );

    // Configuration writes
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl <= `LSS_CTRL_RST;
            part_thr <= PRESS_W'(`LSS_PART_THR_RST);
            full_thr <= PRESS_W'(`LSS_FULL_THR_RST);
            ret_spd <= SPEED_W'(`LSS_RET_SPD_RST);
            act_spd <= SPEED_W'(`LSS_ACT_SPD_RST); // [R11]
            deact_spd <= SPEED_W'(`LSS_DEACT_SPD_RST); // [R12]
            irq_mask <= '0;
        end
        else if (bus_req.wr)
        begin
            if (sel_ctrl)
                ctrl <= bus_req.wdata[`LSS_CTRL_W-1:0];
            else if (sel_part)
                part_thr <= bus_req.wdata[PRESS_W-1:0];
            else if (sel_full)
                full_thr <= bus_req.wdata[PRESS_W-1:0];
            else if (sel_ret)
                ret_spd <= bus_req.wdata[SPEED_W-1:0];
            else if (sel_act)
                act_spd <= bus_req.wdata[SPEED_W-1:0];
            else if (sel_deact)
                deact_spd <= bus_req.wdata[SPEED_W-1:0];
            else if (sel_imask)
                irq_mask <= bus_req.wdata[`LSS_IRQ_W-1:0];
        end
    end

    // Sticky status, write one to clear, new event wins
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            irq_stat <= '0;
        else if (wr_istat)
            irq_stat <= (irq_stat & ~bus_req.wdata[`LSS_IRQ_W-1:0])
                        | irq_evt;
        else
            irq_stat <= irq_stat | irq_evt;
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            bus_rdata <= 32'h0000_0000;
        else if (bus_req.rd)
            bus_rdata <= rd_val;
        else
            bus_rdata <= 32'h0000_0000;
    end

    // Edge history of the trigger inputs, activation compare and switch level
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            spd_above_q <= 1'b0;
            ign_q <= 1'b0;
            act_q <= 1'b0;
            sw_q <= 1'b0;
        end
        else
        begin
            spd_above_q <= spd_above;
            ign_q <= evt.ignition;
            act_q <= at_act;
            sw_q <= sw_lvl;
        end
    end

    // Latched load state, held between detections
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            load_state <= LSS_UNLADEN;
            det_valid <= 1'b0;
        end
        else if (detect)
        begin
            load_state <= load_now; // [R16]
            det_valid <= 1'b1;
        end
    end

    // Continuous mode level with hysteresis band
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cont_on <= 1'b0;
        else if (mode != LSS_MODE_CONT)
            cont_on <= 1'b0;
        else if (at_act)
            cont_on <= 1'b1; // [R07]
        else if (below_deact)
            cont_on <= 1'b0; // [R08]
        // Between the two speeds the level holds [R17]
    end

    // Pulse modes fire once per pass over activation speed
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            armed <= 1'b1;
        else if (fire)
            armed <= 1'b0;
        else if (below_deact)
            armed <= 1'b1;
    end

    // Output stage, all from flip-flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            driving_level_return <= 1'b0;
            general_io_port <= 2'b00;
        end
        else
        begin
            driving_level_return <= sw_lvl ^ invert; // [R13]
            general_io_port[0] <= evt.roll_stability_event
                && ctrl[`LSS_CTRL_PORT_ROLL]; // [R14]
            general_io_port[1] <= evt.anti_lock_event
                && ctrl[`LSS_CTRL_PORT_LOCK]; // [R15]
        end
    end

    // Level interrupt from unmasked sticky bits
    assign irq = |(irq_stat & irq_mask);

endmodule

// File: logic/lss_params.svh
// What this block does
// R01 - Pressure below partial threshold means unladen
// R02 - Pressure between thresholds inclusive means partial
// R03 - Pressure above full threshold means laden
// R04 - Detect on return speed or ignition
// R05 - Both triggers may be enabled together
// R06 - Auto leveling: detect at standstill instead
// R07 - Switch activates at activation speed
// R08 - Continuous mode drops below deactivation speed
// R09 - Timed mode holds output thirty seconds
// R10 - Valve mode emits sequence, ignores deactivation
// R11 - Activation speed resets to fifteen km/h
// R12 - Deactivation speed set two below activation
// R13 - Inversion reverses solenoid output polarity
// R14 - Port follows roll stability intervention
// R15 - Port follows anti-lock control process
// R16 - Load state held until next trigger
// R17 - Continuous mode keeps output within hysteresis
`ifndef LSS_PARAMS_SVH
`define LSS_PARAMS_SVH

// Register byte offsets
`define LSS_OFS_CTRL 8'h00
`define LSS_OFS_PART_THR 8'h04
`define LSS_OFS_FULL_THR 8'h08
`define LSS_OFS_RET_SPD 8'h0C
`define LSS_OFS_ACT_SPD 8'h10
`define LSS_OFS_DEACT_SPD 8'h14
`define LSS_OFS_STATUS 8'h18
`define LSS_OFS_IRQ_STAT 8'h1C
`define LSS_OFS_IRQ_MASK 8'h20

// Control register fields
`define LSS_CTRL_TRIG_SPD 0
`define LSS_CTRL_TRIG_IGN 1
`define LSS_CTRL_AUTO_LVL 2
`define LSS_CTRL_MODE_LO 3
`define LSS_CTRL_MODE_HI 4
`define LSS_CTRL_INVERT 5
`define LSS_CTRL_PORT_ROLL 6
`define LSS_CTRL_PORT_LOCK 7
`define LSS_CTRL_W 8

// Status register fields
`define LSS_ST_LOAD_LO 0
`define LSS_ST_LOAD_HI 1
`define LSS_ST_VALID 2
`define LSS_ST_SWITCH 3

// Interrupt bits
`define LSS_IRQ_DETECT 0
`define LSS_IRQ_CHANGE 1
`define LSS_IRQ_SW_ON 2
`define LSS_IRQ_SW_OFF 3
`define LSS_IRQ_W 4

// Reset values
`define LSS_CTRL_RST 8'hC1
`define LSS_ACT_SPD_RST 15
`define LSS_DEACT_SPD_RST 13
`define LSS_RET_SPD_RST 10
`define LSS_PART_THR_RST 16'h0400
`define LSS_FULL_THR_RST 16'h0C00

// Timing
`define LSS_CLK_HZ 64'd200000000
`define LSS_PULSE_S 64'd30
`define LSS_VALVE_ON_MS 64'd500
`define LSS_VALVE_OFF_MS 64'd500
`define LSS_VALVE_PULSES 3

`endif

// File: logic/lss_pkg.sv
package lss_pkg;

    // Load classification
    typedef enum logic [1:0] {
        LSS_UNLADEN,
        LSS_PARTIAL,
        LSS_LADEN
    } lss_load_t;

    // Speed switch behaviour
    typedef enum logic [1:0] {
        LSS_MODE_CONT,
        LSS_MODE_PULSE,
        LSS_MODE_VALVE
    } lss_mode_t;

    // Register port request from software
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lss_bus_req_t;

    // Level inputs from the brake controller
    typedef struct packed {
        logic ignition;
        logic roll_stability_event;
        logic anti_lock_event;
    } lss_evt_t;

endpackage

// File: logic/lss_pulse_seq.sv
`timescale 1ns/1ps
`include "lss_params.svh"

module lss_pulse_seq
    import lss_pkg::*;
#(
    parameter int CNT_W = 40,
    parameter logic [CNT_W-1:0] ON_CYC = 40'd100,
    parameter logic [CNT_W-1:0] OFF_CYC = 40'd100,
    parameter int PULSES = 1
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    output logic level,
    output logic busy
);

    // Sequencer states
    typedef enum logic [1:0] {SQ_IDLE, SQ_ON, SQ_OFF} lss_seq_t;

    lss_seq_t state; // Current phase
    lss_seq_t next_state; // Next phase
    logic [CNT_W-1:0] cnt; // Cycles left in phase
    logic [CNT_W-1:0] next_cnt;
    logic [7:0] left; // Pulses still to send
    logic [7:0] next_left;

    // Refuse shapes the counters cannot hold
    if (PULSES < 1 || PULSES > 255 || ON_CYC == '0 || OFF_CYC == '0)
    begin : g_chk
        $error("lss_pulse_seq: bad pulse shape");
    end

    // Phase sequencing
    always_comb
    begin
        next_state = state;
        next_cnt = cnt;
        next_left = left;
        case (state)
            SQ_IDLE:
            begin
                if (start)
                begin
                    next_state = SQ_ON;
                    next_cnt = ON_CYC - 1'b1;
                    next_left = 8'(PULSES - 1);
                end
            end
            SQ_ON:
            begin
                if (cnt != '0)
                    next_cnt = cnt - 1'b1;
                else if (left == 8'h00)
                    next_state = SQ_IDLE;
                else
                begin
                    next_state = SQ_OFF;
                    next_cnt = OFF_CYC - 1'b1;
                end
            end
            SQ_OFF:
            begin
                if (cnt != '0)
                    next_cnt = cnt - 1'b1;
                else
                begin
                    next_state = SQ_ON;
                    next_cnt = ON_CYC - 1'b1;
                    next_left = left - 8'h01;
                end
            end
            default:
                next_state = SQ_IDLE;
        endcase
    end

    // State registers
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= SQ_IDLE;
            cnt <= '0;
            left <= 8'h00;
        end
        else
        begin
            state <= next_state;
            cnt <= next_cnt;
            left <= next_left;
        end
    end

    assign level = (state == SQ_ON);
    assign busy = (state != SQ_IDLE);

endmodule

// File: test/lss_top_assertions.sv
`timescale 1ns/1ps
`include "lss_params.svh"

module lss_top_assertions
    import lss_pkg::*;
#(
    parameter int SPEED_W = 8,
    parameter int PRESS_W = 16
)(
    input wire logic clk,
    input wire logic rstn,
    input wire lss_bus_req_t bus_req,
    input wire logic [31:0] bus_rdata,
    input wire logic [SPEED_W-1:0] speed,
    input wire logic [PRESS_W-1:0] pressure,
    input wire lss_evt_t evt,
    input wire logic driving_level_return,
    input wire logic [1:0] general_io_port,
    input wire lss_load_t load_state,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic [7:0] ctrl; // Shadow of the control register
    wire logic [2:0] sel; // Invert bit and switch mode
    wire logic lvl; // Solenoid output
    assign sel = ctrl[5:3];
    assign lvl = driving_level_return;
    // Follow control writes seen on the bus
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ctrl <= `LSS_CTRL_RST;
        else if (bus_req.wr && bus_req.addr == `LSS_OFS_CTRL)
            ctrl <= bus_req.wdata[7:0];
    end
    port_roll_a: assert property ($past(rstn) |->
        general_io_port[0] == $past(evt.roll_stability_event & ctrl[6]))
        else $error("roll output wrong");
    port_lock_a: assert property ($past(rstn) |->
        general_io_port[1] == $past(evt.anti_lock_event & ctrl[7]))
        else $error("anti-lock output wrong");
    rdata_idle_a: assert property (!$past(bus_req.rd) |-> bus_rdata == 0)
        else $error("read data outside read slot");
    laden_cause_a: assert property (
        load_state != $past(load_state) && load_state == LSS_LADEN
        |-> $past(pressure) > `LSS_FULL_THR_RST) else $error("laden wrong");
    unladen_cause_a: assert property (
        load_state != $past(load_state) && load_state == LSS_UNLADEN
        |-> $past(pressure) < `LSS_PART_THR_RST) else $error("unladen wrong");
    cont_on_a: assert property (
        (sel == 3'h0 && speed >= `LSS_ACT_SPD_RST)[*3] |-> lvl)
        else $error("switch not on");
    cont_off_a: assert property (
        (sel == 3'h0 && speed < `LSS_DEACT_SPD_RST)[*3] |-> !lvl)
        else $error("switch not off");
    invert_a: assert property (
        (sel == 3'h4 && speed < `LSS_DEACT_SPD_RST)[*3] |-> lvl)
        else $error("inverted switch not on");
    pulse_len_a: assert property (
        $rose(lvl) && sel == 3'h1 |-> ##19 lvl ##1 !lvl)
        else $error("pulse length wrong");
    valve_on_a: assert property (
        $rose(lvl) && sel == 3'h2 |-> lvl[*5] ##1 !lvl)
        else $error("valve pulse wrong");
    pulse_c: cover property ($rose(lvl) && sel == 3'h1);
    laden_c: cover property ($changed(load_state) && load_state == LSS_LADEN);
    irq_c: cover property ($rose(irq));
endmodule

bind lss_top lss_top_assertions #(
    .SPEED_W(SPEED_W),
    .PRESS_W(PRESS_W)
) lss_top_assertions_inst (
    .clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .speed(speed), .pressure(pressure), .evt(evt), .irq(irq),
    .driving_level_return(driving_level_return),
    .general_io_port(general_io_port), .load_state(load_state)
);

// File: test/lss_vehicle.sv
`timescale 1ns/1ps

module lss_vehicle
    import lss_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic driving_level_return,
    output logic [7:0] speed,
    output logic [15:0] pressure,
    output lss_evt_t evt,
    output logic [7:0] valve_count
);
    logic last; // Solenoid level one cycle ago
    // Controller starts at standstill, no events
    initial
    begin
        speed = 8'h0;
        pressure = 16'h0;
        evt = 3'h0;
    end
    // New controller values land just after an edge
    task automatic put(input logic [7:0] s, input logic [15:0] p,
        input lss_evt_t e);
        @(posedge clk);
        speed <= s;
        pressure <= p;
        evt <= e;
    endtask
    // Height valve counts each actuation
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            last <= 1'b0;
            valve_count <= 8'h0;
        end
        else
        begin
            last <= driving_level_return;
            valve_count <= valve_count + 8'(driving_level_return & ~last);
        end
    end
endmodule

// File: test/test_lss_top.sv
`timescale 1ns/1ps
`include "lss_params.svh"

module test_lss_top
    import lss_pkg::*;
();
    logic clk;
    logic rstn;
    lss_bus_req_t bus_req;
    logic [31:0] bus_rdata;
    logic [7:0] speed;
    logic [15:0] pressure;
    lss_evt_t evt;
    logic driving_level_return;
    logic [1:0] general_io_port;
    lss_load_t load_state;
    logic irq;
    logic [7:0] valve_count;
    int num_errors = 0;
    int check_count = 0;

    lss_top #(
        .PULSE_CYCLES(40'h14),
        .VALVE_ON_CYCLES(40'h5),
        .VALVE_OFF_CYCLES(40'h5)
    ) lss_top_inst (
        .clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .speed(speed), .pressure(pressure), .evt(evt), .irq(irq),
        .driving_level_return(driving_level_return),
        .general_io_port(general_io_port), .load_state(load_state)
    );
    lss_vehicle lss_vehicle_inst (
        .clk(clk), .rstn(rstn), .driving_level_return(driving_level_return),
        .speed(speed), .pressure(pressure), .evt(evt),
        .valve_count(valve_count)
    );
    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req <= '0;
    endtask
    // One-cycle read, data judged in the cycle after
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req <= '0;
        #1;
        chk("rdata", exp, bus_rdata);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic go(input logic [7:0] s, input logic [15:0] p,
        input lss_evt_t e);
        lss_vehicle_inst.put(s, p, e);
    endtask
    // Speed crosses the return speed with the given pressure
    task automatic by_speed(input logic [15:0] p);
        go(8'h0, p, 3'h0);
        go(8'hB, p, 3'h0);
        tick(2);
    endtask
    task automatic t_load();
        logic [15:0] p [4] = '{16'h03FF, 16'h0400, 16'h0C00, 16'h0C01};
        logic [1:0] e [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
        rd(`LSS_OFS_ACT_SPD, 32'hF);
        rd(8'h24, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            by_speed(p[i]);
            chk("load", 32'(e[i]), 32'(load_state));
        end
        go(8'h0, 16'h0, 3'h0);
        tick(3);
        chk("held", 32'h2, 32'(load_state));
        wr(`LSS_OFS_CTRL, 32'hC2);
        by_speed(16'h0100);
        chk("no speed", 32'h2, 32'(load_state));
        go(8'hB, 16'h0100, 3'h4);
        tick(2);
        chk("ignition", 32'h0, 32'(load_state));
        wr(`LSS_OFS_CTRL, 32'hC3);
        by_speed(16'h0800);
        chk("both spd", 32'h1, 32'(load_state));
        go(8'h0, 16'h0C01, 3'h0);
        go(8'h0, 16'h0C01, 3'h4);
        tick(2);
        chk("both ign", 32'h2, 32'(load_state));
        wr(`LSS_OFS_CTRL, 32'hC5);
        go(8'h5, 16'h0100, 3'h0);
        tick(3);
        chk("moving", 32'h2, 32'(load_state));
        go(8'h0, 16'h0100, 3'h0);
        tick(2);
        chk("stand", 32'h0, 32'(load_state));
        // Status: unladen, detection done, switch off
        rd(`LSS_OFS_STATUS, 32'h4);
        wr(`LSS_OFS_CTRL, 32'hC1);
        $display("test load done");
    endtask
    task automatic t_irq();
        wr(`LSS_OFS_IRQ_STAT, 32'hF);
        wr(`LSS_OFS_IRQ_MASK, 32'h1);
        by_speed(16'h0800);
        chk("irq", 32'h1, 32'(irq));
        wr(`LSS_OFS_IRQ_STAT, 32'h1);
        tick(1);
        chk("irq clr", 32'h0, 32'(irq));
        wr(`LSS_OFS_IRQ_MASK, 32'h0);
        by_speed(16'h0100);
        chk("irq mask", 32'h0, 32'(irq));
        rd(`LSS_OFS_IRQ_STAT, 32'h3);
        $display("test irq done");
    endtask
    task automatic t_switch();
        logic [7:0] s [4] = '{8'hF, 8'hE, 8'hC, 8'hE};
        logic e [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        logic [7:0] n0;
        logic [31:0] n;
        // Keep the deactivation speed two below activation
        wr(`LSS_OFS_DEACT_SPD, 32'hD);
        for (int i = 0; i < 4; i++)
        begin
            go(s[i], 16'h0, 3'h0);
            tick(3);
            chk("cont", 32'(e[i]), 32'(driving_level_return));
        end
        // Detect bits from before plus switch on and off edges
        rd(`LSS_OFS_IRQ_STAT, 32'hF);
        wr(`LSS_OFS_CTRL, 32'hC9);
        go(8'h0, 16'h0, 3'h0);
        go(8'hF, 16'h0, 3'h0);
        go(8'h0, 16'h0, 3'h0);
        n = 0;
        repeat (40)
        begin
            @(posedge clk);
            #1;
            n += 32'(driving_level_return);
        end
        chk("pulse", 32'h14, 32'(n));
        wr(`LSS_OFS_CTRL, 32'hD1);
        n0 = valve_count;
        go(8'hF, 16'h0, 3'h0);
        go(8'h0, 16'h0, 3'h0);
        tick(40);
        chk("valve", 32'h3, 32'(valve_count - n0));
        wr(`LSS_OFS_CTRL, 32'hE1);
        tick(3);
        chk("inv", 32'h1, 32'(driving_level_return));
        // Mode three keeps the solenoid off even above activation
        wr(`LSS_OFS_CTRL, 32'hD9);
        go(8'hF, 16'h0, 3'h0);
        tick(3);
        chk("off mode", 32'h0, 32'(driving_level_return));
        go(8'h0, 16'h0, 3'h0);
        wr(`LSS_OFS_CTRL, 32'hC1);
        $display("test switch done");
    endtask
    task automatic t_port();
        go(8'h0, 16'h0, 3'h2);
        tick(1);
        chk("port", 32'h1, 32'(general_io_port));
        go(8'h0, 16'h0, 3'h1);
        tick(1);
        chk("port", 32'h2, 32'(general_io_port));
        wr(`LSS_OFS_CTRL, 32'h01);
        go(8'h0, 16'h0, 3'h3);
        tick(1);
        chk("port off", 32'h0, 32'(general_io_port));
        $display("test port done");
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Main sequence after a 10-cycle reset
    initial
    begin
        rstn = 1'b0;
        bus_req = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_load();
        t_irq();
        t_switch();
        t_port();
        conclude();
    end
    // Cut a hang short
    initial
    begin
        #20000;
        num_errors++;
        conclude();
    end
endmodule
